// >>> pkg/phy_mgmt_regs.svh
/*
   Offsets, field positions, reset values and frame counts of the PHY
   management access block. Definitions only; included by bare name.
*/
`ifndef PHY_MGMT_REGS_SVH
`define PHY_MGMT_REGS_SVH

// register offsets (byte addresses)
`define DATA_OFFSET     12'h0a4
`define CTRL_OFFSET     12'h0a8
`define EMUL_BASE       12'h1c0

// access register field positions
`define PHY_ADDR_MSB    15
`define PHY_ADDR_LSB    11
`define REG_IDX_MSB     10
`define REG_IDX_LSB     6
`define WNR_BIT         1
`define BUSY_BIT        0

// reset values
`define FIELD_RESET     5'h00
`define DATA_RESET      16'h0000

// emulated register indexes served
`define IDX_LAST_LOW    5'h06
`define IDX_SPECIAL     5'h1f
`define SLOT_SPECIAL    3'h7

// serial frame counts
`define PREAMBLE_BITS   6'h20
`define HDR_LAST        6'h0b
`define DATA_LAST       6'h0f
`define OP_READ         2'h2
`define OP_WRITE        2'h1

`endif

// >>> pkg/phy_mgmt_pkg.sv
/*
   Types of the PHY management access block: serial slave states and
   the state records of both modules. Assumes nothing else.
*/
package phy_mgmt_pkg;

   typedef enum logic [4:0] {
      S_PRE   = 5'b0_0001,
      S_START = 5'b0_0010,
      S_HDR   = 5'b0_0100,
      S_TA    = 5'b0_1000,
      S_DATA  = 5'b1_0000
   } serial_state_t;

   typedef struct packed {
      logic [2:0]    mdc_sync;
      logic [2:0]    mdio_sync;
      logic          mdc_level;
      logic          mdio_level;
      serial_state_t state;
      logic [5:0]    count;
      logic [11:0]   header;
      logic [15:0]   shift;
      logic          matched;
      logic          is_read;
      logic          out;
      logic          oe;
      logic          wr;
      logic [4:0]    index;
      logic [15:0]   wdata;
   } serial_regs_t;

   typedef struct packed {
      logic [4:0]        phy_addr;
      logic [4:0]        reg_idx;
      logic              wnr;
      logic              busy;
      logic [15:0]       sw_data;
      logic [15:0]       phy_data;
      logic              req;
      logic [31:0]       rdata;
      logic [7:0][15:0]  emul;
      logic [4:0]        strap;
      logic              strap_taken;
   } engine_regs_t;

endpackage : phy_mgmt_pkg

// >>> pkg/emul_access_if.sv
/*
   Carrier between the serial management slave and the emulated
   register set. Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface emul_access_if;
   logic        wr;
   logic [4:0]  index;
   logic [15:0] wdata;
   logic [15:0] rdata;

   modport provider  (input wr, input index, input wdata, output rdata);
   modport requester (output wr, output index, output wdata, input rdata);
endinterface : emul_access_if

// >>> rtl/mdio_serial_slave.sv
/*
   Clause 22 serial management slave for the emulated PHY register set.
   Assumes mdc and mdio_in are asynchronous pins and that the register
   set answers rdata combinationally for the index it is given.
*/
`timescale 1ns/1ps
`include "phy_mgmt_regs.svh"
module mdio_serial_slave (
   input  wire logic                clk,
   input  wire logic                reset_n,
   input  wire logic                mdc,
   input  wire logic                mdio_in,
   output logic                     mdio_out,
   output logic                     mdio_oe,
   input  wire logic                phy_mode,
   input  wire logic [4:0]          strap_addr,
   emul_access_if.requester         bus
);
   localparam phy_mgmt_pkg::serial_regs_t SERIAL_RESET =
      '{state: phy_mgmt_pkg::S_PRE, default: '0};

   phy_mgmt_pkg::serial_regs_t r_reg;
   phy_mgmt_pkg::serial_regs_t r_next;
   logic                       mdc_agree;
   logic                       rise;
   logic                       bit_in;
   logic [11:0]                hdr;

   always_comb begin
      r_next = r_reg;
      r_next.wr = 1'b0;
      r_next.mdc_sync = {r_reg.mdc_sync[1:0], mdc};
      r_next.mdio_sync = {r_reg.mdio_sync[1:0], mdio_in};
      mdc_agree = (r_reg.mdc_sync[1] == r_reg.mdc_sync[2]);
      rise = mdc_agree && r_reg.mdc_sync[2] && !r_reg.mdc_level;
      bit_in = (r_reg.mdio_sync[1] == r_reg.mdio_sync[2]) ?
               r_reg.mdio_sync[2] : r_reg.mdio_level;
      hdr = {r_reg.header[10:0], bit_in};
      if (mdc_agree) begin
         r_next.mdc_level = r_reg.mdc_sync[2];
      end
      r_next.mdio_level = bit_in;
      if (rise) begin
         unique case (r_reg.state)
            phy_mgmt_pkg::S_PRE: begin
               if (bit_in) begin
                  if (r_reg.count != `PREAMBLE_BITS) begin
                     r_next.count = r_reg.count + 6'h01;
                  end
               end else if (r_reg.count == `PREAMBLE_BITS) begin
                  r_next.state = phy_mgmt_pkg::S_START;
               end else begin
                  r_next.count = '0;
               end
            end
            phy_mgmt_pkg::S_START: begin
               r_next.count = '0;
               r_next.state = bit_in ? phy_mgmt_pkg::S_HDR
                                     : phy_mgmt_pkg::S_PRE;
            end
            phy_mgmt_pkg::S_HDR: begin
               r_next.header = hdr;
               r_next.count = r_reg.count + 6'h01;
               if (r_reg.count == `HDR_LAST) begin
                  r_next.is_read = (hdr[11:10] == `OP_READ);
                  // silent unless strap address and PHY mode match
                  r_next.matched = phy_mode && (hdr[9:5] == strap_addr)
                     && (hdr[11:10] == `OP_READ
                         || hdr[11:10] == `OP_WRITE);
                  r_next.index = hdr[4:0];
                  r_next.count = '0;
                  r_next.state = phy_mgmt_pkg::S_TA;
               end
            end
            phy_mgmt_pkg::S_TA: begin
               r_next.count = r_reg.count + 6'h01;
               if (r_reg.count == '0) begin
                  // first turnaround bit left floating, then drive zero
                  r_next.oe = r_reg.matched && r_reg.is_read;
                  r_next.out = 1'b0;
                  r_next.shift = bus.rdata;
               end else begin
                  r_next.out = r_reg.shift[15];
                  r_next.shift = {r_reg.shift[14:0], 1'b0};
                  r_next.count = '0;
                  r_next.state = phy_mgmt_pkg::S_DATA;
               end
            end
            phy_mgmt_pkg::S_DATA: begin
               r_next.count = r_reg.count + 6'h01;
               if (r_reg.is_read) begin
                  r_next.out = r_reg.shift[15];
                  r_next.shift = {r_reg.shift[14:0], 1'b0};
               end else begin
                  r_next.shift = {r_reg.shift[14:0], bit_in};
               end
               if (r_reg.count == `DATA_LAST) begin
                  r_next.oe = 1'b0;
                  r_next.out = 1'b0;
                  r_next.wdata = {r_reg.shift[14:0], bit_in};
                  r_next.wr = r_reg.matched && !r_reg.is_read;
                  r_next.count = '0;
                  r_next.state = phy_mgmt_pkg::S_PRE;
               end
            end
            default: begin
               r_next = SERIAL_RESET;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r_reg <= SERIAL_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   assign mdio_out = r_reg.out;
   assign mdio_oe = r_reg.oe;
   assign bus.wr = r_reg.wr;
   assign bus.index = r_reg.index;
   assign bus.wdata = r_reg.wdata;

   property p_drive_needs_match;
      @(posedge clk) disable iff (!reset_n)
      mdio_oe |-> r_reg.matched && r_reg.is_read;
   endproperty
   a_drive_needs_match: assert property (p_drive_needs_match)
      else $error("mdio driven for an unmatched frame");

   property p_mac_mode_silent;
      @(posedge clk) disable iff (!reset_n)
      (rise && r_reg.state == phy_mgmt_pkg::S_HDR
       && r_reg.count == `HDR_LAST && !phy_mode) |=> !r_reg.matched;
   endproperty
   a_mac_mode_silent: assert property (p_mac_mode_silent)
      else $error("frame accepted outside PHY mode");

   property p_sixteen_bits;
      @(posedge clk) disable iff (!reset_n)
      r_reg.state == phy_mgmt_pkg::S_DATA |-> r_reg.count <= `DATA_LAST;
   endproperty
   a_sixteen_bits: assert property (p_sixteen_bits)
      else $error("serial data phase longer than sixteen bits");
endmodule : mdio_serial_slave

// >>> rtl/phy_mgmt_indirect_access.sv
/*
   PHY management access: indirect access engine toward the internal
   PHYs plus the emulated PHY register set, reached both from the
   register port and from the serial management slave.
   Assumes one clock, a register master that keeps the busy handshake,
   and internal PHY logic answering mgmt_req with one mgmt_done pulse.
*/
//
// Summary of operation
// - access register write launches one cycle
// - bits 15:11 select PHY, reset zero
// - bits 10:6 select register, reset zero
// - write data held until busy clears
// - read data invalid until busy clears
// - indirect cycles never reach emulated registers
// - emulated set via memory and serial frames
// - serial access only in PHY mode
// - answer only strap-matching PHY address
// - serial registers are sixteen bits wide
// - fixed serial index decode list
// - emulated set follows standard register layout
// - data read depends on direction bit
//
`timescale 1ns/1ps
`include "phy_mgmt_regs.svh"
module phy_mgmt_indirect_access (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [11:0] addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   output logic             mgmt_req,
   output logic      [4:0]  mgmt_phy_addr,
   output logic      [4:0]  mgmt_reg_index,
   output logic             mgmt_write,
   output logic      [15:0] mgmt_wdata,
   input  wire logic        mgmt_done,
   input  wire logic [15:0] mgmt_rdata,
   input  wire logic        mdc,
   input  wire logic        mdio_in,
   output logic             mdio_out,
   output logic             mdio_oe,
   input  wire logic        phy_mode,
   input  wire logic [4:0]  phy_addr_strap
);
   localparam logic [11:0] EMUL_BASE_A = `EMUL_BASE;

   phy_mgmt_pkg::engine_regs_t r_reg;
   phy_mgmt_pkg::engine_regs_t r_next;
   emul_access_if              link ();

   logic       ctrl_wr;
   logic       data_wr;
   logic       emul_hit;
   logic [3:0] serial_slot;

   // index decode: {served, slot}; slots 0..6 direct, 31 in slot 7
   function automatic logic [3:0] slot_of(input logic [4:0] idx);
      logic [3:0] s;
      s = 4'h0;
      if (idx <= `IDX_LAST_LOW) begin
         s = {1'b1, idx[2:0]};
      end else if (idx == `IDX_SPECIAL) begin
         s = {1'b1, `SLOT_SPECIAL};
      end
      return s;
   endfunction : slot_of

   mdio_serial_slave serial (
      .clk        (clk),
      .reset_n    (reset_n),
      .mdc        (mdc),
      .mdio_in    (mdio_in),
      .mdio_out   (mdio_out),
      .mdio_oe    (mdio_oe),
      .phy_mode   (phy_mode),
      .strap_addr (r_reg.strap),
      .bus        (link.requester)
   );

   always_comb begin
      serial_slot = slot_of(link.index);
      // unlisted indexes answer zero
      link.rdata = serial_slot[3] ? r_reg.emul[serial_slot[2:0]]
                                  : `DATA_RESET;
   end

   always_comb begin
      r_next = r_reg;
      r_next.req = 1'b0;
      r_next.rdata = '0;
      ctrl_wr = wr && (addr == `CTRL_OFFSET);
      data_wr = wr && (addr == `DATA_OFFSET);
      emul_hit = (addr[11:5] == EMUL_BASE_A[11:5]) && (addr[1:0] == 2'h0);

      // strap sampled once, the first edge after reset release
      if (!r_reg.strap_taken) begin
         r_next.strap = phy_addr_strap;
         r_next.strap_taken = 1'b1;
      end

      // writes during busy are dropped so the driven data stays put
      if (data_wr && !r_reg.busy) begin
         r_next.sw_data = wdata[15:0];
      end
      if (ctrl_wr && !r_reg.busy) begin
         r_next.phy_addr = wdata[`PHY_ADDR_MSB:`PHY_ADDR_LSB];
         r_next.reg_idx = wdata[`REG_IDX_MSB:`REG_IDX_LSB];
         r_next.wnr = wdata[`WNR_BIT];
         r_next.busy = 1'b1;
         r_next.req = 1'b1;
      end
      if (r_reg.busy && mgmt_done) begin
         r_next.busy = 1'b0;
         if (!r_reg.wnr) begin
            r_next.phy_data = mgmt_rdata;
         end
      end

      // emulated set: register port then serial slave; the indirect
      // engine has no path into it
      if (wr && emul_hit) begin
         r_next.emul[addr[4:2]] = wdata[15:0];
      end
      if (link.wr && serial_slot[3]) begin
         r_next.emul[serial_slot[2:0]] = link.wdata;
      end

      if (rd) begin
         if (addr == `DATA_OFFSET) begin
            r_next.rdata = {16'h0000,
               r_reg.wnr ? r_reg.sw_data : r_reg.phy_data};
         end else if (addr == `CTRL_OFFSET) begin
            r_next.rdata = {16'h0000, r_reg.phy_addr, r_reg.reg_idx,
                            4'h0, r_reg.wnr, r_reg.busy};
         end else if (emul_hit) begin
            // memory view pads the sixteen-bit register
            r_next.rdata = {16'h0000, r_reg.emul[addr[4:2]]};
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign rdata = r_reg.rdata;
   assign mgmt_req = r_reg.req;
   assign mgmt_phy_addr = r_reg.phy_addr;
   assign mgmt_reg_index = r_reg.reg_idx;
   assign mgmt_write = r_reg.wnr;
   assign mgmt_wdata = r_reg.sw_data;

   sequence s_launch;
      ctrl_wr && !r_reg.busy;
   endsequence

   sequence s_finish;
      r_reg.busy && mgmt_done;
   endsequence

   property p_launch;
      @(posedge clk) disable iff (!reset_n)
      s_launch |=> mgmt_req && r_reg.busy ##1 !mgmt_req;
   endproperty
   a_launch: assert property (p_launch)
      else $error("access write did not launch exactly one cycle");

   property p_fields;
      @(posedge clk) disable iff (!reset_n)
      s_launch |=> mgmt_phy_addr == $past(wdata[15:11])
               && mgmt_reg_index == $past(wdata[10:6]);
   endproperty
   a_fields: assert property (p_fields)
      else $error("launched PHY or register index wrong");

   property p_direction;
      @(posedge clk) disable iff (!reset_n)
      s_launch |=> mgmt_write == $past(wdata[1]);
   endproperty
   a_direction: assert property (p_direction)
      else $error("launched direction wrong");

   property p_busy_clears;
      @(posedge clk) disable iff (!reset_n)
      s_finish |=> !r_reg.busy ##1 (!r_reg.busy || $past(ctrl_wr));
   endproperty
   a_busy_clears: assert property (p_busy_clears)
      else $error("busy did not self-clear on completion");

   property p_hold_write_data;
      @(posedge clk) disable iff (!reset_n)
      r_reg.busy && r_reg.wnr |=> $stable(mgmt_wdata);
   endproperty
   a_hold_write_data: assert property (p_hold_write_data)
      else $error("write data changed while busy");

   property p_read_return;
      @(posedge clk) disable iff (!reset_n)
      s_finish ##0 !r_reg.wnr ##1 (rd && addr == `DATA_OFFSET)
         |=> rdata[15:0] == $past(mgmt_rdata, 2);
   endproperty
   a_read_return: assert property (p_read_return)
      else $error("read result not returned in data register");

   property p_reserved_zero;
      @(posedge clk) disable iff (!reset_n)
      rd && addr == `CTRL_OFFSET |=> rdata[31:16] == 16'h0000
                                  && rdata[5:2] == 4'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved access bits not zero");

   property p_unlisted_zero;
      @(posedge clk) disable iff (!reset_n)
      // watched at the pin, not at the mux that makes the value
      mdio_oe && !serial_slot[3] |-> !mdio_out;
   endproperty
   a_unlisted_zero: assert property (p_unlisted_zero)
      else $error("unlisted serial index read not zero on the pin");
endmodule : phy_mgmt_indirect_access

// >>> testbench/phy_side_model.sv
/*
   Behavioural model of the internal PHYs behind the indirect port.
   Assumes one outstanding cycle and engine outputs held until done.
*/
`timescale 1ns/1ps
module phy_side_model (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        mgmt_req,
   input  wire logic [4:0]  mgmt_phy_addr,
   input  wire logic [4:0]  mgmt_reg_index,
   input  wire logic        mgmt_write,
   input  wire logic [15:0] mgmt_wdata,
   input  wire logic [3:0]  delay,
   output logic             mgmt_done,
   output logic      [15:0] mgmt_rdata,
   output int               req_count,
   output logic             order_err
);
   logic [15:0] mem [0:1023];
   logic [9:0]  slot;
   logic [15:0] held;
   logic [3:0]  wait_cnt;
   logic        pending;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < 1024; i++) begin
            mem[i] = 16'h5000 + 16'(i);
         end
         mgmt_done  <= 1'b0;
         mgmt_rdata <= 16'h0000;
         req_count  <= 0;
         order_err  <= 1'b0;
         pending    <= 1'b0;
         wait_cnt   <= 4'h0;
      end else begin
         mgmt_done  <= 1'b0;
         // never hold a stale value outside the answer cycle
         mgmt_rdata <= ~mgmt_rdata;
         if (mgmt_req) begin
            req_count <= req_count + 1;
            if (pending) order_err <= 1'b1;
            pending  <= 1'b1;
            slot     <= {mgmt_phy_addr, mgmt_reg_index};
            held     <= mgmt_wdata;
            wait_cnt <= (delay == 4'h0) ? 4'h1 : delay;
         end else if (pending) begin
            if (mgmt_write && mgmt_wdata !== held) order_err <= 1'b1;
            if (wait_cnt == 4'h1) begin
               pending   <= 1'b0;
               mgmt_done <= 1'b1;
               if (mgmt_write) mem[slot] <= held;
               else mgmt_rdata <= mem[slot];
            end
            wait_cnt <= wait_cnt - 4'h1;
         end
      end
   end
endmodule : phy_side_model

// >>> testbench/tb_top.sv
/*
   Self-checking bench of the PHY management access block.
   Assumes the PHY model beside it and a pulled-up mdio line.
*/
`timescale 1ns/1ps
`include "phy_mgmt_regs.svh"
module tb_top;
   logic        clk, reset_n, wr, rd, mgmt_req, mgmt_write, mgmt_done;
   logic        mdc, mdio_wire, mdio_out, mdio_oe, phy_mode;
   logic        m_oe, m_val, oe_seen, order_err;
   logic [11:0] addr;
   logic [31:0] wdata, rdata, v;
   logic [4:0]  mgmt_phy_addr, mgmt_reg_index, phy_addr_strap;
   logic [15:0] mgmt_wdata, mgmt_rdata, sampled;
   logic [3:0]  delay;
   int          fails, num_checks, cycles, req_count, base;
   logic [4:0]  idx_tab [8] = '{5'h00, 5'h01, 5'h02, 5'h03,
                                5'h04, 5'h05, 5'h06, 5'h1f};

   // released line floats high through the pull-up
   assign mdio_wire = mdio_oe ? mdio_out : (m_oe ? m_val : 1'b1);

   phy_mgmt_indirect_access phy_mgmt_indirect_access_inst (.clk, .reset_n,
      .addr, .wdata, .wr, .rd, .rdata, .mgmt_req, .mgmt_phy_addr,
      .mgmt_reg_index, .mgmt_write, .mgmt_wdata, .mgmt_done, .mgmt_rdata,
      .mdc, .mdio_in(mdio_wire), .mdio_out, .mdio_oe, .phy_mode,
      .phy_addr_strap);

   phy_side_model phy_side_model_inst (.clk, .reset_n, .mgmt_req,
      .mgmt_phy_addr, .mgmt_reg_index, .mgmt_write, .mgmt_wdata, .delay,
      .mgmt_done, .mgmt_rdata, .req_count, .order_err);

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask : check

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [11:0] a, output logic [31:0] d);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask : reg_read

   task automatic wait_idle;
      logic [31:0] s;
      int          n;
      s = 32'h1;
      n = 0;
      while (s[0] !== 1'b0 && n < 40) begin
         reg_read(`CTRL_OFFSET, s);
         n++;
      end
      check({31'h0, s[0]}, 32'h0);
   endtask : wait_idle

   function automatic logic [11:0] emul_off(input int k);
      return (k == 7) ? 12'h1dc : `EMUL_BASE + 12'(4 * k);
   endfunction : emul_off

   // one mdc period: low six cycles, sampled just before the rise
   task automatic sbit(input logic drv, input logic val);
      @(posedge clk);
      mdc   <= 1'b0;
      m_oe  <= drv;
      m_val <= val;
      repeat (5) @(posedge clk);
      @(negedge clk);
      sampled = {sampled[14:0], mdio_wire};
      @(posedge clk);
      mdc <= 1'b1;
      repeat (4) @(posedge clk);
   endtask : sbit

   task automatic frame(input logic [1:0] op, input logic [4:0] pa,
                        input logic [4:0] ra, input logic [15:0] wd);
      logic [13:0] hdr;
      hdr = {2'b01, op, pa, ra};
      oe_seen = 1'b0;
      for (int i = 0; i < 32; i++) sbit(1'b1, 1'b1);
      for (int i = 13; i >= 0; i--) sbit(1'b1, hdr[i]);
      sbit(op == `OP_WRITE, 1'b1);
      sbit(op == `OP_WRITE, 1'b0);
      for (int i = 15; i >= 0; i--) sbit(op == `OP_WRITE, wd[i]);
      @(posedge clk);
      mdc  <= 1'b0;
      m_oe <= 1'b0;
      repeat (10) @(posedge clk);
   endtask : frame

   always @(posedge clk) begin
      if (mdio_oe === 1'b1) oe_seen = 1'b1;
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         fails++;
         complete_run();
      end
   end

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      {reset_n, wr, rd, mdc, m_oe, m_val} = 6'h00;
      addr = 12'h000;
      wdata = 32'h0000_0000;
      phy_mode = 1'b1;
      phy_addr_strap = 5'h03;
      delay = 4'hc;
      {fails, num_checks, cycles} = {32'h0, 32'h0, 32'h0};
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      reg_read(`CTRL_OFFSET, v);
      check(v, 32'h0000_0000);
      reg_read(`DATA_OFFSET, v);
      check(v, 32'h0000_0000);
      $display("test reset values done");

      reg_write(`DATA_OFFSET, 32'hffff_beef);
      base = req_count;
      reg_write(`CTRL_OFFSET, 32'hffff_093f);
      reg_read(`CTRL_OFFSET, v);
      check(v, 32'h0000_0903);
      check({16'h0, mgmt_phy_addr, mgmt_reg_index, 5'h0, mgmt_write},
            32'h0000_0901);
      reg_write(`DATA_OFFSET, 32'h0000_1111);
      reg_write(`CTRL_OFFSET, 32'h0000_0000);
      check({16'h0, mgmt_wdata}, 32'h0000_beef);
      wait_idle();
      check(req_count - base, 1);
      reg_read(`DATA_OFFSET, v);
      check(v, 32'h0000_beef);
      $display("test indirect write done");

      delay <= 4'h1;
      reg_write(`CTRL_OFFSET, 32'h0000_0900);
      // done comes two edges on: data read the cycle after busy clears
      repeat (2) @(posedge clk);
      reg_read(`DATA_OFFSET, v);
      check(v, 32'h0000_beef);
      wait_idle();
      delay <= 4'hf;
      reg_write(`CTRL_OFFSET, 32'h0000_ffc0);
      wait_idle();
      reg_read(`DATA_OFFSET, v);
      check(v, 32'h0000_53ff);
      check({31'h0, order_err}, 32'h0);
      $display("test indirect read done");

      base = req_count;
      for (int k = 0; k < 8; k++) reg_write(emul_off(k), 32'hffff_3c00 + k);
      for (int k = 0; k < 8; k++) begin
         reg_read(emul_off(k), v);
         check(v, 32'h0000_3c00 + k);
      end
      reg_write(12'h1e0, 32'h0000_5555);
      reg_read(12'h1e0, v);
      check(v, 32'h0000_0000);
      check(req_count - base, 0);
      $display("test emulated map done");

      for (int k = 0; k < 8; k++) begin
         frame(`OP_READ, 5'h03, idx_tab[k], 16'h0000);
         check({16'h0, sampled}, 32'h0000_3c00 + k);
      end
      frame(`OP_WRITE, 5'h03, 5'h07, 16'h1234);
      frame(`OP_READ, 5'h03, 5'h07, 16'h0000);
      check({15'h0, oe_seen, sampled}, 32'h0001_0000);
      frame(`OP_WRITE, 5'h03, 5'h1f, 16'hc3a5);
      reg_read(12'h1dc, v);
      check(v, 32'h0000_c3a5);
      $display("test serial access done");

      frame(`OP_READ, 5'h04, 5'h00, 16'h0000);
      check({31'h0, oe_seen}, 32'h0);
      frame(`OP_WRITE, 5'h04, 5'h00, 16'hffff);
      frame(2'h3, 5'h03, 5'h00, 16'h0000);
      check({31'h0, oe_seen}, 32'h0);
      phy_mode <= 1'b0;
      frame(`OP_READ, 5'h03, 5'h00, 16'h0000);
      check({31'h0, oe_seen}, 32'h0);
      frame(`OP_WRITE, 5'h03, 5'h00, 16'hffff);
      reg_read(`EMUL_BASE, v);
      check(v, 32'h0000_3c00);
      $display("test serial refusal done");

      // fields, data and emulated set all hold non-zero values here
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      reg_read(`CTRL_OFFSET, v);
      check(v, 32'h0000_0000);
      reg_read(`DATA_OFFSET, v);
      check(v, 32'h0000_0000);
      reg_read(12'h1dc, v);
      check(v, 32'h0000_0000);
      $display("test mid-run reset done");
      complete_run();
   end
endmodule : tb_top
